/* rtl/xcvr_cfg_pkg.sv */
// Purpose: Shared types and constants for the transceiver mode and link select block.
// Assumes: One 40 MHz system clock; every strap and pin is already synchronous to it.
// Notes: The character widths and loopback codes are fixed by the device's pin behaviour.
package xcvr_cfg_pkg;

  // System clock period in picoseconds (40 MHz)
  localparam int CLK_PERIOD_PS = 25000;

  // Parallel character widths for each data format
  localparam logic [3:0] WIDTH_ENC8 = 4'h8;
  localparam logic [3:0] WIDTH_RAW10 = 4'ha;
  localparam logic [3:0] WIDTH_ENC10 = 4'ha;
  localparam logic [3:0] WIDTH_RAW12 = 4'hc;

  // Reference clock rising edges that must pass with reset held (one full period)
  localparam logic [1:0] REF_HOLD_EDGES = 2'h2;

  // Reset values of registered outputs
  localparam logic RST_LINK_FAULT_N = 1'h0;
  localparam logic RST_LOGIC_RESET = 1'h1;

  // Data formats decoded from the width and codec straps
  typedef enum logic [1:0] {
    FMT_ENC8 = 2'b00,
    FMT_RAW10 = 2'b01,
    FMT_ENC10 = 2'b10,
    FMT_RAW12 = 2'b11
  } data_fmt_t;

  // Loopback select codes
  typedef enum logic [1:0] {
    LOOP_NONE = 2'b00,
    LOOP_DIAG = 2'b01,
    LOOP_THRU_PRI = 2'b10,
    LOOP_THRU_SEC = 2'b11
  } loop_mode_t;

  // Decoded static configuration, carried as one word
  typedef struct packed {
    data_fmt_t fmt;
    logic [3:0] char_width;
    logic codec_en;
    logic buffers_en;
    logic stuffer_en;
    logic cfg_illegal;
  } xcvr_cfg_t;

  // Reset value of the decoded configuration (8-bit encoded, buffers on)
  localparam xcvr_cfg_t RST_CFG = '{fmt: FMT_ENC8, char_width: WIDTH_ENC8, codec_en: 1'h1,
                                    buffers_en: 1'h1, stuffer_en: 1'h0, cfg_illegal: 1'h0};

endpackage : xcvr_cfg_pkg

/* rtl/xcvr_mode_link_sel.sv */
// Purpose: Strap decode, global logic reset, receive input steering, loopback and link fault.
// Assumes: Straps are static; ref_clk_a and rx_clk_b arrive as sampled levels on clock_in.
// Notes: Serial data is handled here as sampled bits; the analog paths sit outside.
//
// Function
// - Width high, codec on: 8-bit encoded mode
// - Width high, codec bypassed: 10 raw bits
// - Width low, codec on: 10 bits via stuffer
// - Width low, codec bypassed: 12 raw bits
// - Reset held one reference period resets logic
// - Exactly one serial input feeds recovery
// - Loopback select routes inputs to secondary output
// - Loopback select covers diagnostic and loop-through
// - Carrier absent drives link fault low
// - Link fault steps with receive clock, tracks input
// - Codec bypass low skips encoder and decoder
// - Buffer bypass low skips both buffers
`timescale 1ns/1ps
module xcvr_mode_link_sel
  import xcvr_cfg_pkg::*;
(
  // Clock, reset and enable
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Static straps
  input wire logic char_width_sel_in,
  input wire logic codec_bypass_n_in,
  input wire logic buffer_bypass_n_in,
  input wire logic test_n_in,
  // Global reset pins and reference clock level
  input wire logic [1:0] reset_n_in,
  input wire logic ref_clk_a_in,
  // Receive selection and loopback control
  input wire logic rx_input_sel_in,
  input wire logic [1:0] loopback_sel_in,
  input wire logic rx_clk_b_in,
  // Serial data and link quality
  input wire logic serial_in_primary_in,
  input wire logic serial_in_secondary_in,
  input wire logic tx_serial_in,
  input wire logic primary_signal_ok_in,
  input wire logic secondary_signal_ok_in,
  input wire logic carrier_present_in,
  // Decoded configuration and reset
  output xcvr_cfg_t cfg_out,
  output logic logic_reset_out,
  output logic test_mode_out,
  // Serial routing
  output logic cdr_data_out,
  output logic serial_out_primary_out,
  output logic serial_out_secondary_out,
  // Link status
  output logic link_fault_n_out
);

  // Decode of the three straps into a configuration word
  function automatic xcvr_cfg_t decode_cfg(input logic width_hi, input logic codec_n,
                                           input logic buf_n);
    xcvr_cfg_t c;
    c = RST_CFG;
    c.codec_en = codec_n;
    c.buffers_en = buf_n;
    c.stuffer_en = 1'h0;
    if (width_hi && codec_n)
    begin
      c.fmt = FMT_ENC8;
      c.char_width = WIDTH_ENC8;
    end
    else if (width_hi)
    begin
      c.fmt = FMT_RAW10;
      c.char_width = WIDTH_RAW10;
    end
    else if (codec_n)
    begin
      c.fmt = FMT_ENC10;
      c.char_width = WIDTH_ENC10;
      c.stuffer_en = 1'h1;
    end
    else
    begin
      c.fmt = FMT_RAW12;
      c.char_width = WIDTH_RAW12;
    end
    // Buffers bypassed with codec on forbids the 10-bit width
    c.cfg_illegal = !buf_n && codec_n && !width_hi;
    return c;
  endfunction : decode_cfg

  // Internal state
  logic ref_prev_ff; // Last reference clock level, for edge detect
  logic rx_prev_ff; // Last receive clock level, for edge detect
  logic [1:0] hold_cnt_ff; // Reference edges seen with reset held
  logic cfg_loaded_ff; // Straps captured at least once since system reset
  logic logic_reset_ff;
  xcvr_cfg_t cfg_ff;
  logic test_mode_ff;
  logic cdr_data_ff;
  logic out_pri_ff;
  logic out_sec_ff;
  logic link_fault_n_ff;

  // Combinational helpers
  logic both_rst_low; // Both reset bits low in the same cycle
  logic ref_rise;
  logic rx_rise;
  logic sel_ok; // Selected input fit for recovery
  loop_mode_t loop_mode;
  logic nxt_cdr_data;
  logic nxt_out_sec;

  assign both_rst_low = (reset_n_in == 2'b00);
  assign ref_rise = ref_clk_a_in && !ref_prev_ff;
  assign rx_rise = rx_clk_b_in && !rx_prev_ff;
  assign loop_mode = loop_mode_t'(loopback_sel_in);
  assign sel_ok = rx_input_sel_in ? primary_signal_ok_in : secondary_signal_ok_in;

  // Edge detectors for the sampled clock levels
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      ref_prev_ff <= 1'h0;
      rx_prev_ff <= 1'h0;
    end
    else if (clk_en_in)
    begin
      ref_prev_ff <= ref_clk_a_in;
      rx_prev_ff <= rx_clk_b_in;
    end
  end

  // Global reset qualifier: a glitch shorter than one reference period is ignored,
  // and a lone low bit never counts, so a half-driven pair cannot reset the core
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      hold_cnt_ff <= 2'h0;
      logic_reset_ff <= RST_LOGIC_RESET;
    end
    else if (clk_en_in)
    begin
      if (!both_rst_low)
      begin
        // Release or single-bit low: restart the count
        hold_cnt_ff <= 2'h0;
        logic_reset_ff <= 1'h0;
      end
      else if (hold_cnt_ff == REF_HOLD_EDGES)
      begin
        logic_reset_ff <= 1'h1;
      end
      else if (ref_rise)
      begin
        hold_cnt_ff <= hold_cnt_ff + 2'h1;
      end
    end
  end

  // Strap capture: taken once after system reset and again on each global reset,
  // so a strap moved during operation has no effect until the next reset
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      cfg_loaded_ff <= 1'h0;
      cfg_ff <= RST_CFG;
    end
    else if (clk_en_in)
    begin
      if (!cfg_loaded_ff || logic_reset_ff)
      begin
        cfg_loaded_ff <= 1'h1;
        cfg_ff <= decode_cfg(char_width_sel_in, codec_bypass_n_in, buffer_bypass_n_in);
      end
    end
  end

  // Factory test request flag; the core never acts on it beyond reporting it
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      test_mode_ff <= 1'h0;
    else if (clk_en_in)
      test_mode_ff <= !test_n_in;
  end

  // Serial steering: one input to recovery, loopback choices to the secondary output
  always_comb
  begin
    nxt_cdr_data = rx_input_sel_in ? serial_in_primary_in : serial_in_secondary_in;
    nxt_out_sec = tx_serial_in;
    case (loop_mode)
      LOOP_NONE:
        nxt_out_sec = tx_serial_in;
      LOOP_DIAG:
        // Diagnostic loopback: transmit stream goes into recovery instead
        nxt_cdr_data = tx_serial_in;
      LOOP_THRU_PRI:
        nxt_out_sec = serial_in_primary_in;
      LOOP_THRU_SEC:
        nxt_out_sec = serial_in_secondary_in;
      default:
        nxt_out_sec = tx_serial_in;
    endcase
  end

  // Registered serial outputs; one cycle of latency keeps every output on a flop
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      cdr_data_ff <= 1'h0;
      out_pri_ff <= 1'h0;
      out_sec_ff <= 1'h0;
    end
    else if (clk_en_in)
    begin
      cdr_data_ff <= nxt_cdr_data;
      out_pri_ff <= tx_serial_in;
      out_sec_ff <= nxt_out_sec;
    end
  end

  // Link fault: updated only on receive clock rising edges, so a carrier drop
  // shows at the next receive edge rather than at once
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      link_fault_n_ff <= RST_LINK_FAULT_N;
    else if (clk_en_in && rx_rise)
      link_fault_n_ff <= carrier_present_in && sel_ok;
  end

  // Outputs straight from flops
  assign cfg_out = cfg_ff;
  assign logic_reset_out = logic_reset_ff;
  assign test_mode_out = test_mode_ff;
  assign cdr_data_out = cdr_data_ff;
  assign serial_out_primary_out = out_pri_ff;
  assign serial_out_secondary_out = out_sec_ff;
  assign link_fault_n_out = link_fault_n_ff;

  // Checks
  a_fault_on_carrier: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && rx_rise && !carrier_present_in) |=> !link_fault_n_out)
    else $error("link fault not raised on carrier loss");

  a_fault_steps_rx: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !(clk_en_in && rx_rise) |=> $stable(link_fault_n_out))
    else $error("link fault moved without receive clock edge");

  a_fault_bad_input: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && rx_rise && !sel_ok) |=> !link_fault_n_out)
    else $error("link fault missed on unusable input");

  a_cdr_one_input: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && loop_mode != LOOP_DIAG) |=>
      cdr_data_out == ($past(rx_input_sel_in) ? $past(serial_in_primary_in) : $past(serial_in_secondary_in)))
    else $error("recovery path not fed by selected input");

  a_loop_thru_pri: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && loop_mode == LOOP_THRU_PRI) |=> serial_out_secondary_out == $past(serial_in_primary_in))
    else $error("loop-through of primary input missing");

  a_loop_diag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && loop_mode == LOOP_DIAG) |=> cdr_data_out == $past(tx_serial_in))
    else $error("diagnostic loopback not routed");

  a_reset_both_bits: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && !both_rst_low) |=> !logic_reset_out)
    else $error("logic reset with only one reset bit low");

  a_reset_needs_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && !logic_reset_out && hold_cnt_ff != REF_HOLD_EDGES) |=> !logic_reset_out)
    else $error("logic reset before one reference period");

  a_fmt_decode: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (cfg_loaded_ff && cfg_out.fmt == FMT_ENC8) |-> (cfg_out.char_width == WIDTH_ENC8 && cfg_out.codec_en))
    else $error("8-bit encoded format inconsistent");

  a_raw12_decode: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (clk_en_in && logic_reset_out && !char_width_sel_in && !codec_bypass_n_in) |=>
      (cfg_out.char_width == WIDTH_RAW12 && !cfg_out.codec_en))
    else $error("12-bit raw format not decoded");

  a_strap_frozen: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (cfg_loaded_ff && !logic_reset_out) |=> $stable(cfg_out))
    else $error("configuration changed outside global reset");

endmodule : xcvr_mode_link_sel

/* verif/host_side_model.sv */
// Purpose: Host board and optical module model that drives reset pins and clocks.
// Assumes: Pins change just after falling edges of clock_in.
// Notes: Reference and receive clocks run free, four system cycles per period.
`timescale 1ns/1ps
module host_side_model
(
  // Clock and commands from the bench
  input wire logic clock_in,
  input wire logic glob_rst_in,
  input wire logic half_rst_in,
  // Pins towards the block
  output logic [1:0] reset_n_out,
  output logic ref_clk_a_out,
  output logic rx_clk_b_out,
  output logic test_n_out
);
  // Clock divider, starts known so both clocks are defined at once
  logic [1:0] div_ff = 2'h0;

  // Factory test select is strapped inactive for the whole run
  assign test_n_out = 1'h1;
  // Both bits move together; half_rst_in breaks the pairing on purpose
  assign reset_n_out = glob_rst_in ? {1'h0, half_rst_in} : 2'h3;

  // Free running clocks; the bench holds reset for several full periods
  always @(negedge clock_in)
  begin
    div_ff <= div_ff + 2'h1;
  end
  assign ref_clk_a_out = div_ff[1];
  assign rx_clk_b_out = div_ff[1];
endmodule : host_side_model

/* verif/xcvr_mode_link_sel_bench.sv */
// Purpose: Self-checking bench for the mode decode, reset, steering and link fault.
// Assumes: Inputs change 1 ns after falling edges; outputs read one cycle later.
// Notes: Expected values are queued by the driver and checked by a watcher.
`timescale 1ns/1ps
module xcvr_mode_link_sel_bench;
  import xcvr_cfg_pkg::*;
  // Expected result note
  typedef struct {int kind; logic [9:0] exp;} note_t;
  logic clock_in, sys_rst_in, char_width_sel_in, codec_bypass_n_in, buffer_bypass_n_in;
  logic test_n_in, ref_clk_a_in, rx_clk_b_in, rx_input_sel_in, glob_rst, half_rst;
  logic serial_in_primary_in, serial_in_secondary_in, tx_serial_in;
  logic primary_signal_ok_in, secondary_signal_ok_in, carrier_present_in, rx_prev;
  logic [1:0] reset_n_in, loopback_sel_in;
  logic [31:0] rnd;
  logic [9:0] seen;
  logic clk_en;
  xcvr_cfg_t cfg_out;
  logic logic_reset_out, test_mode_out, cdr_data_out, serial_out_primary_out;
  logic serial_out_secondary_out, link_fault_n_out;
  note_t notes[$];
  note_t n;
  int num_errors = 0;
  int checks = 0;
  int t;
  event look;
  string names[7] = '{"cfg", "cdr", "sec_out", "pri_out", "fault_n", "lreset", "tmode"};

  // Every input is driven from the bench or the far-side model
  xcvr_mode_link_sel dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
    .char_width_sel_in(char_width_sel_in), .codec_bypass_n_in(codec_bypass_n_in),
    .buffer_bypass_n_in(buffer_bypass_n_in), .test_n_in(test_n_in), .reset_n_in(reset_n_in),
    .ref_clk_a_in(ref_clk_a_in), .rx_input_sel_in(rx_input_sel_in),
    .loopback_sel_in(loopback_sel_in), .rx_clk_b_in(rx_clk_b_in),
    .serial_in_primary_in(serial_in_primary_in), .serial_in_secondary_in(serial_in_secondary_in),
    .tx_serial_in(tx_serial_in), .primary_signal_ok_in(primary_signal_ok_in),
    .secondary_signal_ok_in(secondary_signal_ok_in), .carrier_present_in(carrier_present_in),
    .cfg_out(cfg_out), .logic_reset_out(logic_reset_out), .test_mode_out(test_mode_out),
    .cdr_data_out(cdr_data_out), .serial_out_primary_out(serial_out_primary_out),
    .serial_out_secondary_out(serial_out_secondary_out), .link_fault_n_out(link_fault_n_out));

  // Far side: reset pair, reference and receive clocks, test strap
  host_side_model partner (.clock_in(clock_in), .glob_rst_in(glob_rst), .half_rst_in(half_rst),
    .reset_n_out(reset_n_in), .ref_clk_a_out(ref_clk_a_in), .rx_clk_b_out(rx_clk_b_in),
    .test_n_out(test_n_in));

  // 40 MHz clock
  initial
  begin
    clock_in = 1'h0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Advance whole cycles; the watcher runs before the driver moves on
  task step(input int cnt);
    repeat (cnt)
    begin
      @(negedge clock_in);
      ->look;
      #1;
    end
  endtask : step

  task note(input int k, input logic [9:0] v);
    notes.push_back('{k, v});
  endtask : note

  task note_bit(input int k, input logic b);
    note(k, {9'h0, b});
  endtask : note_bit

  // Decode of width, codec and buffer straps {W, C, B}
  function automatic xcvr_cfg_t exp_cfg(input logic [2:0] s);
    xcvr_cfg_t c;
    c.fmt = data_fmt_t'({~s[2], ~s[1]});
    c.char_width = s[2] ? (s[1] ? WIDTH_ENC8 : WIDTH_RAW10) : (s[1] ? WIDTH_ENC10 : WIDTH_RAW12);
    c.codec_en = s[1];
    c.buffers_en = s[0];
    c.stuffer_en = !s[2] && s[1];
    c.cfg_illegal = !s[0] && s[1] && !s[2];
    return c;
  endfunction : exp_cfg

  // Watcher: every queued note is compared with the output it names
  always @(look)
  begin
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        0: seen = cfg_out;
        1: seen = {9'h0, cdr_data_out};
        2: seen = {9'h0, serial_out_secondary_out};
        3: seen = {9'h0, serial_out_primary_out};
        4: seen = {9'h0, link_fault_n_out};
        5: seen = {9'h0, logic_reset_out};
        default: seen = {9'h0, test_mode_out};
      endcase
      checks++;
      if (seen !== n.exp)
      begin
        num_errors++;
        $display("FAIL %s expected %h seen %h", names[n.kind], n.exp, seen);
      end
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Watchdog against a hung run
  initial
  begin
    #2000000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    sys_rst_in = 1'h1;
    clk_en = 1'h1;
    {char_width_sel_in, codec_bypass_n_in, buffer_bypass_n_in} = 3'h7;
    {glob_rst, half_rst, rx_input_sel_in, loopback_sel_in} = 5'h04;
    {serial_in_primary_in, serial_in_secondary_in, tx_serial_in} = 3'h0;
    // Edge tracker starts high so a receive clock already high is not taken for a rise
    {primary_signal_ok_in, secondary_signal_ok_in, carrier_present_in, rx_prev} = 4'hf;
    rnd = $urandom(99908);
    step(16);
    // Every strap combination, captured after a system reset
    for (int i = 0; i < 8; i++)
    begin
      sys_rst_in = 1'h1;
      {char_width_sel_in, codec_bypass_n_in, buffer_bypass_n_in} = i[2:0];
      step(2);
      sys_rst_in = 1'h0;
      step(3);
      note(0, exp_cfg(i[2:0]));
      note_bit(6, 1'h0);
      step(1);
    end
    $display("test decode done");
    // Strap change without a global reset is ignored
    {char_width_sel_in, codec_bypass_n_in, buffer_bypass_n_in} = 3'h0;
    step(4);
    note(0, exp_cfg(3'h7));
    // One reset bit alone is refused
    {glob_rst, half_rst} = 2'h3;
    step(12);
    note_bit(5, 1'h0);
    step(1);
    {glob_rst, half_rst} = 2'h0;
    step(2);
    // Paired reset over several reference periods
    glob_rst = 1'h1;
    step(12);
    note_bit(5, 1'h1);
    step(1);
    glob_rst = 1'h0;
    step(3);
    note_bit(5, 1'h0);
    note(0, exp_cfg(3'h0));
    step(1);
    $display("test global reset done");
    // Steering and loopback, every selector and code with random bits
    for (int k = 0; k < 64; k++)
    begin
      loopback_sel_in = k[5:4];
      rx_input_sel_in = k[3];
      rnd = $urandom;
      {serial_in_primary_in, serial_in_secondary_in, tx_serial_in} = rnd[2:0];
      note_bit(1, (k[5:4] == 2'h1) ? rnd[0] : (k[3] ? rnd[2] : rnd[1]));
      note_bit(2, (k[5:4] == 2'h2) ? rnd[2] : ((k[5:4] == 2'h3) ? rnd[1] : rnd[0]));
      note_bit(3, rnd[0]);
      step(1);
    end
    // Clock enable low freezes the primary serial output; the old bit must stand
    clk_en = 1'h0;
    note_bit(3, tx_serial_in);
    tx_serial_in = !tx_serial_in;
    step(2);
    clk_en = 1'h1;
    note_bit(3, tx_serial_in);
    step(1);
    $display("test routing done");
    // Link fault from carrier and from the selected input's quality
    rx_input_sel_in = 1'h1;
    step(6);
    note_bit(4, 1'h1);
    step(1);
    carrier_present_in = 1'h0;
    step(6);
    note_bit(4, 1'h0);
    carrier_present_in = 1'h1;
    primary_signal_ok_in = 1'h0;
    step(6);
    note_bit(4, 1'h0);
    step(1);
    rx_input_sel_in = 1'h0;
    step(6);
    note_bit(4, 1'h1);
    // Carrier dropped just after a receive rise waits for the next rise
    for (t = 0; t < 8 && !(rx_clk_b_in && !rx_prev); t++)
    begin
      rx_prev = rx_clk_b_in;
      step(1);
    end
    if (t == 8)
      num_errors++;
    step(1);
    carrier_present_in = 1'h0;
    note_bit(4, 1'h1);
    step(4);
    note_bit(4, 1'h0);
    step(1);
    $display("test link fault done");
    finish_test();
  end
endmodule : xcvr_mode_link_sel_bench
